// *** pfb_bus_model.sv ***
// Far-side model: CPU bus strobes and break control
`timescale 1ns/1ps
module pfb_bus_model (
  input  wire logic         i_rd,     // Read request
  input  wire logic         i_wr,     // Write request
  input  wire logic         i_brk,    // Break state
  input  wire logic         i_clr_en, // Break-clear enable level
  output pfb_pkg::pfb_acc_s o_acc,    // Access strobes
  output pfb_pkg::pfb_brk_s o_brk     // Break controls
);
  assign o_acc = '{rd: i_rd, wr: i_wr};
  assign o_brk = '{brk_active: i_brk, break_clear_enable: i_clr_en};
endmodule

// *** pfb_pkg.sv ***
// Shared types and constants for the PLL event flag break guard
package pfb_pkg;

  // Software access to the PLL control register, one-cycle strobes
  typedef struct packed {
    logic rd;  // Read strobe, a read clears the event flag unless in break with clear disabled or a lock change sets it
    logic wr;  // Write strobe, never touches the event flag
  } pfb_acc_s;

  // Break-side control from the system integration unit
  typedef struct packed {
    logic brk_active;          // Processor is in the break state
    logic break_clear_enable;  // Software may clear flags during break
  } pfb_brk_s;

  localparam logic FLAG_RST      = 1'b0;
  localparam logic BRK_CLR_EN_RST = 1'b0;
  localparam logic RD_DATA_RST   = 1'b0;
  localparam int   LOCK_SYNC_LEN = 2;

endpackage

// *** pfb_pll_flag_guard.sv ***
// PLL event flag with break-state clear protection
`timescale 1ns/1ps

// Contract
// - The break-clear enable from the system integration unit decides if flags may be cleared in break.
// - With the break-clear enable at 1, a clear during break works exactly as outside break.
// - A flag cleared during break stays cleared after break exit, with no restoring.
// - With the break-clear enable at 0, control register accesses in break leave the flag unchanged.
// - The break-clear enable is 0 out of reset, so the flag is protected by default.
// - With automatic bandwidth on, every change of the lock indicator sets the event flag.
// - With automatic bandwidth off, the flag reads as 0 and no PLL interrupt is requested.
// - The PLL interrupt is requested only while its enable and the event flag are both set.
module pfb_pll_flag_guard #(
  parameter int SYNC_LEN = pfb_pkg::LOCK_SYNC_LEN  // Lock synchroniser depth, two or more
) (
  input  wire logic            i_core_clk,         // Bus clock, 125 MHz
  input  wire logic            i_rst,              // Synchronous reset, active high
  input  wire logic            i_ce,               // Clock enable, freezes all state when low
  input  wire logic            i_auto_bw,          // Automatic bandwidth control on
  input  wire logic            i_pll_lock,         // Lock indicator from the PLL, asynchronous
  input  wire logic            i_pll_event_irq_enable, // PLL interrupt enable bit
  input  wire pfb_pkg::pfb_acc_s i_acc,            // Control register access strobes
  input  wire pfb_pkg::pfb_brk_s i_brk,            // Break state and break-clear enable
  output logic                 o_pll_event_flag,   // Flag as software sees it
  output logic                 o_rd_flag,          // Flag bit captured by the last read
  output logic                 o_pll_irq           // PLL interrupt request, level
);

  // A single stage would let a metastable lock sample reach the edge detector
  if (SYNC_LEN < 2) begin : g_sync_len_chk
    $error("SYNC_LEN must be at least 2");
  end

  logic [SYNC_LEN-1:0] lock_sync_r;     // Lock synchroniser, bit 0 first
  logic [SYNC_LEN-1:0] lock_sync_nxt;
  logic                lock_prev_r;     // Synchronised lock one sample back
  logic                lock_prev_nxt;
  logic                brk_clr_en_r;    // Registered break-clear enable
  logic                brk_clr_en_nxt;
  logic                flag_r;          // Raw event flag, kept in manual mode until a permitted read clears it
  logic                flag_nxt;
  logic                rd_flag_r;       // Flag captured by the last read
  logic                rd_flag_nxt;
  logic                lock_sync;       // Last synchroniser stage
  logic                set_ev;          // Lock change seen in automatic mode
  logic                clr_ok;          // Read that may clear the flag

  assign lock_sync = lock_sync_r[SYNC_LEN-1];
  // Lock edges only count in automatic mode
  assign set_ev    = i_auto_bw && (lock_sync != lock_prev_r);
  // Writes are ignored here; only a permitted read clears
  assign clr_ok    = i_acc.rd && (!i_brk.brk_active || brk_clr_en_r);

  // Lock synchroniser and edge memory
  always_comb begin
    lock_sync_nxt = lock_sync_r;
    lock_prev_nxt = lock_prev_r;
    if (i_ce) begin
      lock_sync_nxt = {lock_sync_r[SYNC_LEN-2:0], i_pll_lock};
      lock_prev_nxt = lock_sync;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lock_sync_r <= '0;
      lock_prev_r <= 1'b0;
    end else begin
      lock_sync_r <= lock_sync_nxt;
      lock_prev_r <= lock_prev_nxt;
    end
  end

  // Registered copy of the break-clear enable, one cycle behind its input
  always_comb begin
    brk_clr_en_nxt = brk_clr_en_r;
    if (i_ce) begin
      brk_clr_en_nxt = i_brk.break_clear_enable;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      brk_clr_en_r <= pfb_pkg::BRK_CLR_EN_RST;
    end else begin
      brk_clr_en_r <= brk_clr_en_nxt;
    end
  end

  // Set wins over a clear in the same cycle so no lock change is lost
  always_comb begin
    flag_nxt = flag_r;
    if (i_ce) begin
      if (set_ev) begin
        flag_nxt = 1'b1;
      end else if (clr_ok) begin
        flag_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      flag_r <= pfb_pkg::FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Read data shows 0 in manual mode even though a permitted read still clears the raw flag
  always_comb begin
    rd_flag_nxt = rd_flag_r;
    if (i_ce && i_acc.rd) begin
      rd_flag_nxt = flag_r && i_auto_bw;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rd_flag_r <= pfb_pkg::RD_DATA_RST;
    end else begin
      rd_flag_r <= rd_flag_nxt;
    end
  end

  assign o_pll_event_flag = flag_r && i_auto_bw;
  assign o_rd_flag        = rd_flag_r;
  assign o_pll_irq        = flag_r && i_auto_bw && i_pll_event_irq_enable;

  set_on_lock_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_auto_bw && (lock_sync != lock_prev_r) |=> flag_r)
    else $error("lock change did not set the event flag");

  irq_cause_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_pll_irq |-> flag_r && i_pll_event_irq_enable)
    else $error("interrupt without flag and enable");

  manual_quiet_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_auto_bw |-> !o_pll_irq && !o_pll_event_flag)
    else $error("manual mode shows flag or interrupt");

  brk_protect_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && (i_acc.rd || i_acc.wr) && i_brk.brk_active && !brk_clr_en_r && flag_r |=> flag_r)
    else $error("flag changed by access in protected break");

  brk_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_acc.rd && i_brk.brk_active && brk_clr_en_r && !set_ev |=> !flag_r)
    else $error("permitted break clear did not take effect");

  stays_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !flag_r && !(i_ce && set_ev) ##1 $fell(i_brk.brk_active) |-> !flag_r)
    else $error("flag restored on break exit");

  clr_en_reset_a: assert property (@(posedge i_core_clk)
    i_rst |=> !brk_clr_en_r)
    else $error("break-clear enable not zero after reset");

  rd_data_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_acc.rd |=> o_rd_flag == ($past(flag_r) && $past(i_auto_bw)))
    else $error("read data does not match flag");

  wr_ignored_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_acc.wr && !i_acc.rd && !set_ev |=> flag_r == $past(flag_r))
    else $error("write strobe altered the flag");

  // Clock enable low must freeze every group of state
  ce_freeze_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_ce |=> $stable(flag_r) && $stable(brk_clr_en_r) && $stable(rd_flag_r)
      && $stable(lock_sync_r) && $stable(lock_prev_r))
    else $error("state moved while clock enable was low");

  clr_outside_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_acc.rd && !i_brk.brk_active && !set_ev |=> !flag_r)
    else $error("read outside break did not clear the flag");

  brk_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_brk.brk_active && !brk_clr_en_r && !set_ev |=> $stable(flag_r))
    else $error("protected break let the flag change");

  enable_copy_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce |=> brk_clr_en_r == $past(i_brk.break_clear_enable))
    else $error("break-clear enable copy does not follow its input");

  no_spur_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !flag_r && !(i_ce && set_ev) |=> !flag_r)
    else $error("flag set without a lock change");

  set_wins_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && set_ev && clr_ok |=> flag_r)
    else $error("clear beat a lock change in the same cycle");

  irq_follow_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    flag_r && i_auto_bw && i_pll_event_irq_enable |-> o_pll_irq)
    else $error("interrupt missing with flag and enable set");

  flag_visible_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_auto_bw |-> o_pll_event_flag == flag_r)
    else $error("flag output differs from flag in automatic mode");

  rd_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !(i_ce && i_acc.rd) |=> $stable(o_rd_flag))
    else $error("read data changed without a read");

  rst_quiet_a: assert property (@(posedge i_core_clk)
    i_rst |=> !o_pll_event_flag && !o_pll_irq && !o_rd_flag)
    else $error("outputs not quiet after reset");

  // A one-cycle reset would otherwise show a fall with no read behind it
  fall_cause_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !$past(i_rst) && $fell(flag_r) |-> $past(clr_ok) && $past(i_ce))
    else $error("flag fell without a permitted read");

  flag_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && !i_acc.rd && !set_ev |=> $stable(flag_r))
    else $error("flag changed with no read and no lock change");

endmodule

// *** pfb_pll_flag_guard_tb.sv ***
// Random self-checking bench for the PLL flag guard
`timescale 1ns/1ps
module pfb_pll_flag_guard_tb;
  logic clk = 0, rst = 1, ce = 0, au = 0, lk = 0, ie = 0, rd = 0, wr = 0, bk = 0, en = 0;
  logic f, rf, irq, s1, s2, s3, er, ef, erf;
  logic [31:0] x = 32'h1a;
  int error_cnt = 0, tests_run = 0;
  pfb_pkg::pfb_acc_s acc;
  pfb_pkg::pfb_brk_s brk;
  always #4 clk = ~clk;
  pfb_bus_model PM (.i_rd(rd), .i_wr(wr), .i_brk(bk), .i_clr_en(en), .o_acc(acc), .o_brk(brk));
  pfb_pll_flag_guard DUT (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_auto_bw(au),
    .i_pll_lock(lk), .i_pll_event_irq_enable(ie), .i_acc(acc), .i_brk(brk),
    .o_pll_event_flag(f), .o_rd_flag(rf), .o_pll_irq(irq));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task summarize();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic a, input logic b, input string m);
    tests_run++;
    if (a !== b) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Expected flag: enable copy lags one cycle, set wins over clear
  always @(posedge clk)
    if (rst) {s1, s2, s3, er, ef, erf} <= '0;
    else if (ce) begin
      {s1, s2, s3} <= {lk, s1, s2};
      er <= en;
      ef <= (au && s2 != s3) || (ef && !(rd && (!bk || er)));
      if (rd) erf <= ef && au;
    end
  always @(negedge clk)
    if (!rst) begin
      chk(f, ef && au, "flag");
      chk(rf, erf, "read data");
      chk(irq, ef && au && ie, "irq");
    end
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 0;
    // Auto mode held per phase; lock stays quiet at the end so mode swaps see no edge
    for (int p = 0; p < 300; p++) begin
      x = xs(x);
      au = x[0] | x[1] | (p < 4);
      // Mid-run reset with state live
      if (p == 150) begin
        @(posedge clk);
        #1 rst = 1;
        repeat (2) @(posedge clk);
        #1 rst = 0;
      end
      for (int k = 0; k < 16; k++) begin
        @(posedge clk);
        #1 x = xs(x);
        {ie, wr, bk, en} = x[3:0];
        ce = (|x[6:4]) | (k > 11);
        rd = x[7] & (x[8] | (p < 4)) & (au | x[11]);
        lk = lk ^ (au & x[9] & x[10] & (k < 12));
      end
    end
    summarize();
  end
  initial begin
    #80000;
    error_cnt++;
    summarize();
  end
endmodule
